// ### hdl/fpes_pkg.sv
// package with constants for the flash program/erase and security block
//
// Summary of operation
// - a program row is 64 bytes aligned on a 64-byte boundary
// - program select enters program configuration and arms address/data latching
// - RAM, direct-page registers and debug controller stay reachable when secured
// - each reset copies the nonvolatile option byte into the working options register
// - options bit 0: 0 means secured, 1 means unsecured
// - a programmed secure option byte takes effect at the next reset
// - security removed only by mass erase, then unsecured after next reset
// - working options reads bits 7..1 as zero, always readable, ignores writes
// - normal boot with mode pin high and secured clears debug pin enable
// - HV may be set only with program or erase selected and sequence followed
// - program and erase select are interlocked, never both set
// - while secured, writes to program select have no effect
package fpes_pkg;
    localparam logic [13:0] FPES_ADDR_OPT_WORK = 14'h023c;
    localparam logic [13:0] FPES_ADDR_CTRL     = 14'h023d;
    localparam logic [13:0] FPES_ADDR_OPT_NV   = 14'h3ffc;
    localparam logic [13:0] FPES_FLASH_BASE    = 14'h2000;
    localparam int          FPES_ROW_BYTES     = 64;
    localparam int          FPES_BIT_PGM       = 0;
    localparam int          FPES_BIT_MASS      = 2;
    localparam int          FPES_BIT_HIGH_VOLTAGE_ENABLE      = 3;
    localparam int          FPES_BIT_SECURITY_DISABLE_BIT      = 0;
    localparam int          FPES_CLK_MHZ       = 40;
    localparam int          FPES_TNVS_US       = 5;
    localparam int          FPES_TNVS_CYC      = FPES_TNVS_US * FPES_CLK_MHZ;
    localparam logic [7:0]  FPES_CTRL_RESET    = 8'h00;
    typedef enum logic [2:0] {
        FPES_IDLE   = 3'b000,
        FPES_ARMED  = 3'b001,
        FPES_LATCH  = 3'b011,
        FPES_HIGHV  = 3'b010,
        FPES_ENDING = 3'b110
    } fpes_state_e;
endpackage

// ### hdl/fpes_opt_loader.sv
// option byte loader: copies nonvolatile options at reset release
`timescale 1ns/1ps
`default_nettype none
module fpes_opt_loader (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [7:0] nvOptByte,
    output var  logic       secured,
    output var  logic       loaded
);
    import fpes_pkg::*;
    // ***********************************
    // capture after release
    // ***********************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            secured <= 1'b1;
            loaded  <= 1'b0;
        end else if (!loaded) begin
            secured <= ~nvOptByte[FPES_BIT_SECURITY_DISABLE_BIT];
            loaded  <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### hdl/fpes_flash_ctrl.sv
// flash program/erase sequencer and security top
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_ctrl (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [13:0] busAddr,
    input  wire logic [7:0]  busWdata,
    input  wire logic        busWrite,
    input  wire logic        busRead,
    input  wire logic        busFromDebug,
    input  wire logic        modeSelectPin,
    input  wire logic [7:0]  nvOptByte,
    input  wire logic [7:0]  arrayRdata,
    input  wire logic        debugPinEnableIn,
    input  wire logic        debugPinEnableWrite,
    output logic      [7:0]  busRdata,
    output logic             busHit,
    output logic             arrayProgramMode,
    output logic             arrayEraseMode,
    output logic             arrayHighVoltage,
    output logic             arrayLatch,
    output logic      [13:0] arrayLatchAddr,
    output logic      [7:0]  arrayLatchData,
    output logic             arrayBlocked,
    output logic             debugPinEnable,
    output logic             debugCommBlocked,
    output logic             optLoaded
);
    import fpes_pkg::*;

    logic        secured;
    logic        programSelect;
    logic        massEraseSelect;
    logic        highVoltageEnable;
    logic        rowWritten;
    logic [8:0]  nvsCount;
    fpes_state_e state;
    fpes_state_e next_state;
    logic        ctrlWrite;
    logic        flashWrite;
    logic        flashRead;
    logic        flashAccessBlocked;
    logic        normalBoot;

    // ***********************************
    // decode
    // ***********************************
    function automatic logic inFlash(input logic [13:0] a);
        inFlash = (a >= FPES_FLASH_BASE);
    endfunction

    assign ctrlWrite  = busWrite && (busAddr == FPES_ADDR_CTRL);
    assign flashWrite = busWrite && inFlash(busAddr);
    assign flashRead  = busRead && inFlash(busAddr);
    assign flashAccessBlocked = secured && (busFromDebug || debugPinEnable);

    fpes_opt_loader u_loader (
        .core_clk  (core_clk),
        .reset     (reset),
        .nvOptByte (nvOptByte),
        .secured   (secured),
        .loaded    (optLoaded)
    );

    // ***********************************
    // control register
    // ***********************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            programSelect     <= FPES_CTRL_RESET[FPES_BIT_PGM];
            massEraseSelect   <= FPES_CTRL_RESET[FPES_BIT_MASS];
            highVoltageEnable <= FPES_CTRL_RESET[FPES_BIT_HIGH_VOLTAGE_ENABLE];
        end else if (ctrlWrite) begin // register stays reachable when secured
            // both requested together: neither select changes
            if (!(busWdata[FPES_BIT_PGM] && busWdata[FPES_BIT_MASS])) begin
                if (!secured && !massEraseSelect) begin
                    programSelect <= busWdata[FPES_BIT_PGM];
                end else if (!busWdata[FPES_BIT_PGM]) begin
                    programSelect <= 1'b0;
                end
                if (!programSelect) begin
                    massEraseSelect <= busWdata[FPES_BIT_MASS];
                end else if (!busWdata[FPES_BIT_MASS]) begin
                    massEraseSelect <= 1'b0;
                end
            end
            if (!busWdata[FPES_BIT_HIGH_VOLTAGE_ENABLE]) begin
                highVoltageEnable <= 1'b0;
            end else if ((programSelect || massEraseSelect) && rowWritten
                         && nvsCount == 9'(FPES_TNVS_CYC)) begin
                highVoltageEnable <= 1'b1;
            end
        end
    end

    // ***********************************
    // sequence tracker
    // ***********************************
    always_comb begin
        next_state = state;
        case (state)
            FPES_IDLE:   if (programSelect || massEraseSelect) next_state = FPES_ARMED;
            FPES_ARMED:  if (!(programSelect || massEraseSelect)) next_state = FPES_IDLE;
                         else if (flashWrite && (!flashAccessBlocked || massEraseSelect))
                             next_state = FPES_LATCH; // erase arming write counts
            FPES_LATCH:  if (highVoltageEnable) next_state = FPES_HIGHV;
                         else if (!(programSelect || massEraseSelect)) next_state = FPES_IDLE;
            FPES_HIGHV:  if (!(programSelect || massEraseSelect)) next_state = FPES_ENDING;
            FPES_ENDING: if (!highVoltageEnable) next_state = FPES_IDLE;
            default:     next_state = FPES_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= FPES_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign rowWritten = (state == FPES_LATCH);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            nvsCount <= 9'h000;
        end else if (state != FPES_LATCH) begin
            nvsCount <= 9'h000;
        end else if (nvsCount != 9'(FPES_TNVS_CYC)) begin
            nvsCount <= nvsCount + 9'h001;
        end
    end

    // ***********************************
    // address and data latch
    // ***********************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            arrayLatch     <= 1'b0;
            arrayLatchAddr <= 14'h0000;
            arrayLatchData <= 8'h00;
        end else begin
            arrayLatch <= 1'b0;
            if (flashWrite && !flashAccessBlocked && (programSelect || massEraseSelect)) begin
                arrayLatch     <= 1'b1;
                arrayLatchAddr <= busAddr; // row = addr[13:6]
                arrayLatchData <= busWdata;
            end
        end
    end

    assign arrayProgramMode = programSelect;
    assign arrayEraseMode   = massEraseSelect;
    assign arrayHighVoltage = highVoltageEnable;

    // ***********************************
    // debug pin enable and security
    // ***********************************
    assign normalBoot = 1'b1;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            debugPinEnable   <= 1'b0;
            debugCommBlocked <= 1'b0;
        end else if (!optLoaded) begin
            debugCommBlocked <= modeSelectPin && normalBoot && ~nvOptByte[FPES_BIT_SECURITY_DISABLE_BIT];
            debugPinEnable   <= 1'b0;
        end else if (debugPinEnableWrite && !debugCommBlocked) begin
            debugPinEnable <= debugPinEnableIn;
        end
    end

    assign arrayBlocked = flashAccessBlocked && (flashRead || flashWrite);

    // ***********************************
    // read data
    // ***********************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busRdata <= 8'h00;
            busHit   <= 1'b0;
        end else begin
            busHit   <= 1'b0;
            busRdata <= 8'h00;
            if (busRead) begin
                busHit <= 1'b1;
                if (busAddr == FPES_ADDR_OPT_WORK) begin
                    busRdata <= {7'h00, ~secured};
                end else if (busAddr == FPES_ADDR_CTRL) begin
                    busRdata <= {4'h0, highVoltageEnable, massEraseSelect, 1'b0, programSelect};
                end else if (inFlash(busAddr) && !flashAccessBlocked) begin
                    busRdata <= arrayRdata; // non-flash is never blocked
                end else begin
                    busHit <= inFlash(busAddr);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/fpes_host_model.sv
// host model: software in RAM or a debug host driving the paging window
`timescale 1ns/1ps
`default_nettype none
module fpes_host_model (
    input  wire logic        core_clk,
    input  wire logic [7:0]  busRdata,
    output var  logic [13:0] busAddr,
    output var  logic [7:0]  busWdata,
    output var  logic        busWrite,
    output var  logic        busRead,
    output var  logic        busFromDebug
);
    initial {busAddr, busWdata, busWrite, busRead, busFromDebug} = '0;
    // one window write; caller keeps step order and waits
    // caller never requests wait or stop during a sequence
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busAddr  <= a;
        busWdata <= d;
        busWrite <= 1'b1;
        @(posedge core_clk);
        busWrite <= 1'b0;
        busWdata <= ~d;
    endtask
    // one read, data taken after the answering edge
    task automatic rd(input logic [13:0] a, input logic dbg, output logic [7:0] d);
        @(posedge core_clk);
        busAddr      <= a;
        busFromDebug <= dbg;
        busRead      <= 1'b1;
        @(posedge core_clk);
        busRead      <= 1'b0;
        busFromDebug <= 1'b0;
        #1 d = busRdata;
    endtask
endmodule
`default_nettype wire

// ### sim/fpes_flash_ctrl_properties.sv
// assertion checker for the flash sequencer ports
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_ctrl_properties
    import fpes_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [13:0] busAddr,
    input wire logic [7:0]  busWdata,
    input wire logic        busWrite,
    input wire logic        busRead,
    input wire logic [7:0]  nvOptByte,
    input wire logic [7:0]  busRdata,
    input wire logic        arrayProgramMode,
    input wire logic        arrayEraseMode,
    input wire logic        arrayHighVoltage,
    input wire logic        arrayLatch,
    input wire logic [13:0] arrayLatchAddr,
    input wire logic [7:0]  arrayLatchData,
    input wire logic        arrayBlocked
);
    logic [8:0] sinceLatch;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) sinceLatch <= 9'h000;
        else if (arrayLatch) sinceLatch <= 9'h000;
        else if (sinceLatch != 9'h1ff) sinceLatch <= sinceLatch + 9'h001;
    end
    sequence flashWr;
        busWrite && busAddr >= FPES_FLASH_BASE;
    endsequence
    // ********
    // properties
    // ********
    interlock_held_a: assert property (!(arrayProgramMode && arrayEraseMode))
        else $error("program and erase both selected");
    erase_exclusive_a: assert property ($rose(arrayEraseMode) |-> !$past(arrayProgramMode))
        else $error("erase set while program set");
    hv_selected_a: assert property ($rose(arrayHighVoltage) |-> arrayProgramMode || arrayEraseMode)
        else $error("high voltage without selection");
    hv_setup_a: assert property ($rose(arrayHighVoltage) && arrayProgramMode |-> sinceLatch >= 9'd198)
        else $error("high voltage before setup time");
    latch_capture_a: assert property (flashWr ##0 arrayProgramMode && !arrayBlocked |=> arrayLatch
        && arrayLatchAddr == $past(busAddr) && arrayLatchData == $past(busWdata))
        else $error("flash write not latched");
    blocked_write_a: assert property (flashWr ##0 arrayBlocked |=> !arrayLatch)
        else $error("blocked write latched");
    blocked_read_a: assert property (busRead && arrayBlocked |=> busRdata == 8'h00)
        else $error("blocked read not zero");
    options_read_a: assert property (busRead && busAddr == FPES_ADDR_OPT_WORK
        |=> busRdata == {7'h00, $past(nvOptByte[0])})
        else $error("options read wrong");
endmodule
bind fpes_flash_ctrl fpes_flash_ctrl_properties i_chk (.core_clk, .reset, .busAddr, .busWdata,
    .busWrite, .busRead, .nvOptByte, .busRdata, .arrayProgramMode, .arrayEraseMode,
    .arrayHighVoltage, .arrayLatch, .arrayLatchAddr, .arrayLatchData, .arrayBlocked);
`default_nettype wire

// ### sim/flash_program_erase_security_bench.sv
// testbench for the flash sequencer and security block
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_security_bench;
    import fpes_pkg::*;
    logic        core_clk, reset, modeSelectPin, busWrite, busRead, busFromDebug;
    logic [13:0] busAddr, latchAddr;
    logic [7:0]  nvOptByte, arrayRdata, busWdata, busRdata, latchData, rdv;
    logic        program_select, mass, hv, latch, dpe, commBlk, dpeIn, dpeWr;
    int          fails, comparisons;
    logic [9:0]  rows [4] = '{{8'h01, 2'b10}, {8'h04, 2'b01}, {8'h05, 2'b00}, {8'h08, 2'b00}};
    fpes_host_model i_host (.core_clk, .busRdata, .busAddr, .busWdata, .busWrite, .busRead,
        .busFromDebug);
    fpes_flash_ctrl i_dut (.core_clk, .reset, .busAddr, .busWdata, .busWrite, .busRead,
        .busFromDebug, .modeSelectPin, .nvOptByte, .arrayRdata, .debugPinEnableIn(dpeIn),
        .debugPinEnableWrite(dpeWr), .busRdata, .busHit(), .arrayProgramMode(program_select),
        .arrayEraseMode(mass), .arrayHighVoltage(hv), .arrayLatch(latch),
        .arrayLatchAddr(latchAddr), .arrayLatchData(latchData), .arrayBlocked(),
        .debugPinEnable(dpe), .debugCommBlocked(commBlk), .optLoaded());
    // ********
    // tasks
    // ********
    task automatic chk(input string n, input logic [13:0] e, input logic [13:0] s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic rst(input logic [7:0] nv, input logic ms);
        reset         <= 1'b1;
        nvOptByte     <= nv;
        modeSelectPin <= ms;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        tally_and_finish;
    end
    initial begin
        fails = 0;
        comparisons = 0;
        arrayRdata = 8'ha5;
        dpeIn = 1'b0;
        dpeWr = 1'b0;
        rst(8'hff, 1'b0);
        foreach (rows[i]) begin
            i_host.wr(FPES_ADDR_CTRL, rows[i][9:2]);
            #1 chk("ctrl", {12'h000, rows[i][1:0]}, {12'h000, program_select, mass});
            i_host.wr(FPES_ADDR_CTRL, 8'h00);
        end
        i_host.wr(FPES_ADDR_CTRL, 8'h01);
        i_host.wr(14'h2041, 8'h5a);
        #1 chk("latchAddr", 14'h2041, latchAddr);
        i_host.wr(FPES_ADDR_CTRL, 8'h09);
        #1 chk("hvEarly", 14'h0000, hv);
        repeat (FPES_TNVS_CYC) @(posedge core_clk);
        i_host.wr(FPES_ADDR_CTRL, 8'h09);
        #1 chk("hvOn", 14'h0001, hv);
        i_host.wr(FPES_ADDR_CTRL, 8'h0d);
        #1 chk("massLock", 14'h0000, mass);
        repeat (400) @(posedge core_clk);
        i_host.wr(14'h207f, 8'h3c);
        #1 chk("latchData", 14'h003c, latchData);
        repeat (800) @(posedge core_clk);
        i_host.wr(FPES_ADDR_CTRL, 8'h08);
        #1 chk("pgmOff", 14'h0001, {program_select, hv});
        repeat (200) @(posedge core_clk);
        i_host.wr(FPES_ADDR_CTRL, 8'h00);
        #1 chk("hvOff", 14'h0000, hv);
        i_host.wr(FPES_ADDR_OPT_WORK, 8'h00);
        i_host.rd(FPES_ADDR_OPT_WORK, 1'b0, rdv);
        chk("optOpen", 14'h0001, rdv);
        rst(8'hfe, 1'b1);
        i_host.rd(FPES_ADDR_OPT_WORK, 1'b0, rdv);
        chk("optSecure", 14'h0000, rdv);
        chk("debugPins", 14'h0001, {dpe, commBlk});
        i_host.wr(FPES_ADDR_CTRL, 8'h01);
        #1 chk("pgmSecure", 14'h0000, program_select);
        i_host.rd(FPES_FLASH_BASE, 1'b1, rdv);
        chk("dbgRead", 14'h0000, rdv);
        i_host.rd(FPES_FLASH_BASE, 1'b0, rdv);
        chk("cpuRead", 14'h00a5, rdv);
        i_host.wr(FPES_ADDR_CTRL, 8'h04);
        #1 chk("massSecure", 14'h0001, mass);
        i_host.wr(FPES_ADDR_CTRL, 8'h00);
        rst(8'hfe, 1'b0);
        @(posedge core_clk);
        dpeIn <= 1'b1;
        dpeWr <= 1'b1;
        @(posedge core_clk);
        dpeWr <= 1'b0;
        #1 chk("dpeSet", 14'h0002, {dpe, commBlk});
        i_host.rd(FPES_FLASH_BASE, 1'b0, rdv);
        chk("dpeRead", 14'h0000, rdv);
        rst(8'hff, 1'b1);
        i_host.rd(FPES_ADDR_OPT_WORK, 1'b0, rdv);
        chk("optErased", 14'h0001, rdv);
        tally_and_finish;
    end
endmodule
`default_nettype wire
